//--- hw/fbe_regs.vh
// Purpose: constants for the flash erase / row program sequencer
// Assumes: 32-bit Avalon-MM slave, byte addressed (byte offsets below used as the address)
// Notes: register offsets are byte addresses
`ifndef FBE_REGS_VH
`define FBE_REGS_VH
// ****************************************
// register map (byte offsets)
// ****************************************
`define FBE_OFF_CTRL 4'h0
`define FBE_OFF_ADRL 4'h4
`define FBE_OFF_ADRH 4'h8
`define FBE_OFF_KEY 4'hC
`define FBE_ADDR_W 4
// ****************************************
// control fields
// ****************************************
`define FBE_BIT_START 15
`define FBE_BIT_WRITE_ENABLE_BIT 14
`define FBE_BIT_ERR 13
`define FBE_OP_HI 3
`define FBE_OP_LO 0
`define FBE_OP_ERASE 4'h3
`define FBE_OP_ROW 4'h2
`define FBE_KEY1 8'h55
`define FBE_KEY2 8'hAA
`define FBE_CTRL_RST 16'h0000
// ****************************************
// geometry and timing
// ****************************************
`define FBE_ROW_WORDS 128
`define FBE_BLK_ROWS 8
`define FBE_LAST_WORD 7'h7F
`define FBE_ERASE_US 20
`define FBE_WORD_NS 400
`define FBE_CLK_NS 40
`endif

//--- hw/fbe_key_unlock.v
// Purpose: unlock key sequence detector
// Assumes: one write strobe per key register write
// Notes: armed only by 55h directly followed by AAh
`timescale 1ns/1ns
`default_nettype none
`include "fbe_regs.vh"
module fbe_key_unlock
(
    input wire i_clk,
    input wire i_nrst,
    input wire i_key_wr,
    input wire [7:0] i_key_data,
    input wire i_consume,
    output reg o_armed
);
    reg seen55_q;
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            seen55_q <= 1'b0;
            o_armed <= 1'b0;
        end
        else if (i_key_wr)
        begin
            // any other key write breaks the pair
            seen55_q <= (i_key_data == `FBE_KEY1);
            o_armed <= seen55_q && (i_key_data == `FBE_KEY2);
        end
        else if (i_consume)
        begin
            seen55_q <= 1'b0;
            o_armed <= 1'b0;
        end
    end
endmodule // fbe_key_unlock
`default_nettype wire

//--- hw/fbe_cycle_timer.v
// Purpose: down counter timing one flash cycle
// Assumes: load pulse starts it
// Notes: o_done pulses one cycle at expiry
`timescale 1ns/1ns
`default_nettype none
module fbe_cycle_timer
#(
    parameter W = 16
)
(
    input wire i_clk,
    input wire i_nrst,
    input wire i_load,
    input wire [W-1:0] i_count,
    output reg o_busy,
    output reg o_done
);
    reg [W-1:0] cnt_q;
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt_q <= {W{1'b0}};
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (i_load)
            begin
                cnt_q <= i_count;
                o_busy <= 1'b1;
            end
            else if (o_busy)
            begin
                if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
                begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
                cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // fbe_cycle_timer
`default_nettype wire

//--- hw/fbe_flash_seq.v
// Purpose: flash block erase / row program sequencer with Avalon-MM registers
// Assumes: flash array and latch buffer sit outside; one clock, 25 MHz
// Notes: erase clears 8 rows; row program copies 128 latched words
`timescale 1ns/1ns
`default_nettype none
`include "fbe_regs.vh"
module fbe_flash_seq
#(
    parameter ERASE_CYCLES = (`FBE_ERASE_US * 1000) / `FBE_CLK_NS,
    parameter WORD_CYCLES = (`FBE_WORD_NS + `FBE_CLK_NS - 1) / `FBE_CLK_NS,
    parameter AW = 24,
    parameter DW = 24
)
(
    input wire i_clk,
    input wire i_nrst,
    input wire [`FBE_ADDR_W-1:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    output reg o_cpu_stall,
    output reg o_fl_erase,
    output reg o_fl_write,
    output reg [AW-1:0] o_fl_addr,
    output reg [DW-1:0] o_fl_wdata,
    output reg [6:0] o_latch_idx,
    input wire [DW-1:0] i_latch_data
);
    // ****************************************
    // states
    // ****************************************
    localparam S_IDLE = 2'd0;
    localparam S_ERASE = 2'd1;
    localparam S_ROW = 2'd2;
    localparam S_DONE = 2'd3;

    reg [1:0] st_q;
    reg start_q;
    reg write_enable_bit_q;
    reg err_q;
    reg [3:0] op_q;
    reg [15:0] adrl_q;
    reg [7:0] adrh_q;
    reg [6:0] widx_q;
    // target held for the whole cycle so a late address write cannot split a row
    reg [AW-1:0] base_q;
    reg ack_q;
    wire armed;
    wire tmr_busy;
    wire tmr_done;
    reg tmr_load;
    reg [15:0] tmr_count;
    reg consume;

    // ****************************************
    // bus decode
    // ****************************************
    // a request is taken when no access is being answered in the same cycle
    wire acc = (i_avs_read | i_avs_write) & ~ack_q;
    // writes land only at the edge where the master sees waitrequest low
    wire cmt = i_avs_write & ~o_avs_waitrequest;
    wire wr_ctrl = cmt & (i_avs_address == `FBE_OFF_CTRL);
    wire wr_adrl = cmt & (i_avs_address == `FBE_OFF_ADRL);
    wire wr_adrh = cmt & (i_avs_address == `FBE_OFF_ADRH);
    wire wr_key = cmt & (i_avs_address == `FBE_OFF_KEY) & i_avs_byteenable[0];
    wire start_req = wr_ctrl & i_avs_byteenable[1] & i_avs_writedata[`FBE_BIT_START];
    wire write_enable_bit_new = i_avs_byteenable[1] ? i_avs_writedata[`FBE_BIT_WRITE_ENABLE_BIT] : write_enable_bit_q;
    // the op written together with the start bit is the one that runs
    wire [3:0] op_new = i_avs_byteenable[0] ? i_avs_writedata[`FBE_OP_HI:`FBE_OP_LO] : op_q;
    wire op_ok = (op_new == `FBE_OP_ERASE) | (op_new == `FBE_OP_ROW);
    // start needs write enable, valid op and the armed key
    wire go = start_req & (st_q == S_IDLE) & write_enable_bit_new & armed & op_ok;
    wire [AW-1:0] tgt = {adrh_q, adrl_q};

    fbe_key_unlock u_key
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_key_wr(wr_key),
        .i_key_data(i_avs_writedata[7:0]),
        .i_consume(consume),
        .o_armed(armed)
    );

    fbe_cycle_timer #(.W(16)) u_tmr
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_load(tmr_load),
        .i_count(tmr_count),
        .o_busy(tmr_busy),
        .o_done(tmr_done)
    );

    // ****************************************
    // bus slave: one wait cycle per access
    // ****************************************
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ack_q <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h00000000;
        end
        else
        begin
            ack_q <= acc;
            o_avs_waitrequest <= ~acc;
            case (i_avs_address)
                `FBE_OFF_CTRL: o_avs_readdata <= {16'h0000, start_q, write_enable_bit_q, err_q, 9'h000, op_q};
                `FBE_OFF_ADRL: o_avs_readdata <= {16'h0000, adrl_q};
                `FBE_OFF_ADRH: o_avs_readdata <= {24'h000000, adrh_q};
                default: o_avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            write_enable_bit_q <= 1'b0;
            op_q <= 4'h0;
            err_q <= 1'b0;
            adrl_q <= 16'h0000;
            adrh_q <= 8'h00;
        end
        else
        begin
            if (wr_ctrl)
            begin
                // 0x4003 in one write sets erase with write enable
                if (i_avs_byteenable[0])
                    op_q <= i_avs_writedata[`FBE_OP_HI:`FBE_OP_LO];
                if (i_avs_byteenable[1])
                begin
                    write_enable_bit_q <= i_avs_writedata[`FBE_BIT_WRITE_ENABLE_BIT];
                    err_q <= start_req & ~go;
                end
            end
            if (wr_adrl)
            begin
                if (i_avs_byteenable[0])
                    adrl_q[7:0] <= i_avs_writedata[7:0];
                if (i_avs_byteenable[1])
                    adrl_q[15:8] <= i_avs_writedata[15:8];
            end
            if (wr_adrh & i_avs_byteenable[0])
                adrh_q <= i_avs_writedata[7:0];
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always @*
    begin
        tmr_load = 1'b0;
        tmr_count = 16'h0000;
        consume = go;
        if (go)
        begin
            tmr_load = 1'b1;
            // erase covers the whole 8-row block in one timed cycle
            tmr_count = (op_new == `FBE_OP_ERASE) ? ERASE_CYCLES[15:0] : WORD_CYCLES[15:0];
        end
        else if (st_q == S_ROW && tmr_done && widx_q != `FBE_LAST_WORD)
        begin
            tmr_load = 1'b1;
            tmr_count = WORD_CYCLES[15:0];
        end
    end

    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_q <= S_IDLE;
            start_q <= 1'b0;
            widx_q <= 7'h00;
            o_cpu_stall <= 1'b0;
            o_fl_erase <= 1'b0;
            o_fl_write <= 1'b0;
            o_fl_addr <= {AW{1'b0}};
            o_fl_wdata <= {DW{1'b0}};
            o_latch_idx <= 7'h00;
            base_q <= {AW{1'b0}};
        end
        else
        begin
            o_fl_erase <= 1'b0;
            o_fl_write <= 1'b0;
            case (st_q)
                S_IDLE:
                begin
                    if (go)
                    begin
                        start_q <= 1'b1;
                        o_cpu_stall <= 1'b1;
                        widx_q <= 7'h00;
                        o_latch_idx <= 7'h00;
                        o_fl_addr <= tgt;
                        base_q <= tgt;
                        if (op_new == `FBE_OP_ERASE)
                        begin
                            st_q <= S_ERASE;
                            o_fl_erase <= 1'b1;
                        end
                        else
                            st_q <= S_ROW;
                    end
                end
                S_ERASE:
                begin
                    if (tmr_done)
                        st_q <= S_DONE;
                end
                S_ROW:
                begin
                    if (tmr_done)
                    begin
                        // one latched word per timed slot
                        o_fl_write <= 1'b1;
                        o_fl_wdata <= i_latch_data;
                        o_fl_addr <= base_q + {{(AW-7){1'b0}}, widx_q};
                        if (widx_q == `FBE_LAST_WORD)
                            st_q <= S_DONE;
                        else
                        begin
                            widx_q <= widx_q + 7'h01;
                            o_latch_idx <= widx_q + 7'h01;
                        end
                    end
                end
                S_DONE:
                begin
                    start_q <= 1'b0;
                    o_cpu_stall <= 1'b0;
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule // fbe_flash_seq
`default_nettype wire

//--- verification/fbe_seq_assertions.sv
// Purpose: port checker for the flash sequencer
// Assumes: bench runs with small cycle counts
// Notes: stall bound sized for one row at three cycles a word
`timescale 1ns/1ns
`default_nettype none
module fbe_seq_chk (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic o_cpu_stall,
    input wire logic o_fl_erase,
    input wire logic o_fl_write
);
    localparam int STALL_MAX = 400;
    logic [7:0] wr_cnt_q;
    logic er_q;
    logic start_req;
    assign start_req = i_avs_write && i_avs_address == 4'h0 && i_avs_writedata[15];
    // ********
    // per-cycle tallies, cleared whenever the stall is low
    // ********
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_cnt_q <= 8'h00;
            er_q <= 1'b0;
        end
        else if (!o_cpu_stall)
        begin
            wr_cnt_q <= 8'h00;
            er_q <= 1'b0;
        end
        else
        begin
            wr_cnt_q <= wr_cnt_q + {7'h00, o_fl_write};
            er_q <= er_q | o_fl_erase;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence erase_run;
        o_fl_erase ##1 o_cpu_stall [*3];
    endsequence
    erase_hold_a: assert property (o_fl_erase |-> erase_run)
        else $error("stall dropped right after erase");
    erase_pulse_a: assert property (o_fl_erase |=> !o_fl_erase)
        else $error("erase pulse too long");
    erase_only_a: assert property (o_fl_erase |-> !o_fl_write)
        else $error("write during erase");
    op_stall_a: assert property ((o_fl_erase || o_fl_write) |-> o_cpu_stall)
        else $error("flash access without stall");
    start_cause_a: assert property ($rose(o_cpu_stall) |-> $past(start_req))
        else $error("stall without start write");
    start_op_a: assert property ($rose(o_cpu_stall) |->
        $past(i_avs_writedata[3:0] == 4'h3 || i_avs_writedata[3:0] == 4'h2))
        else $error("cycle began with bad op");
    stall_end_a: assert property ($rose(o_cpu_stall) |-> ##[1:STALL_MAX] !o_cpu_stall)
        else $error("cycle never finished");
    row_count_a: assert property ($fell(o_cpu_stall) |->
        (er_q ? wr_cnt_q == 8'h00 : wr_cnt_q == 8'h80))
        else $error("wrong word count in cycle");
endmodule // fbe_seq_chk
bind fbe_flash_seq fbe_seq_chk u_chk (.i_clk, .i_nrst, .i_avs_address, .i_avs_write,
    .i_avs_writedata, .o_cpu_stall, .o_fl_erase, .o_fl_write);
`default_nettype wire

//--- verification/fbe_flash_model.sv
// Purpose: flash array and latch buffer model
// Assumes: every row is written whole, in order
// Notes: latch word is base xor index
`timescale 1ns/1ns
`default_nettype none
module fbe_flash_model (
    input wire logic i_clk,
    input wire logic i_fl_erase,
    input wire logic i_fl_write,
    input wire logic [23:0] i_fl_addr,
    input wire logic [23:0] i_fl_wdata,
    input wire logic [6:0] i_latch_idx,
    input wire logic [23:0] i_base,
    output logic [23:0] o_latch_data
);
    int n_erase = 0;
    int n_write = 0;
    int n_bad = 0;
    logic [23:0] erase_addr = 24'h000000;
    logic [23:0] wr_addr = 24'h000000;
    assign o_latch_data = i_base ^ {17'h00000, i_latch_idx};
    always @(posedge i_clk)
    begin
        if (i_fl_erase)
        begin
            n_erase <= n_erase + 1;
            erase_addr <= i_fl_addr;
        end
        if (i_fl_write)
        begin
            if (i_fl_wdata !== (i_base ^ {17'h00000, n_write[6:0]}))
                n_bad <= n_bad + 1;
            n_write <= n_write + 1;
            wr_addr <= i_fl_addr;
        end
    end
endmodule // fbe_flash_model
`default_nettype wire

//--- verification/flash_block_erase_row_program_bench.sv
// Purpose: self-checking bench for the flash sequencer
// Assumes: short erase and word times through parameters
// Notes: one idle cycle between bus accesses
`timescale 1ns/1ns
`default_nettype none
module flash_block_erase_row_program_bench;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [3:0] av_adr = 4'h0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] rdata;
    logic wreq;
    logic fl_er;
    logic fl_wr;
    logic stall;
    logic [23:0] fl_adr;
    logic [23:0] fl_wd;
    logic [6:0] lidx;
    logic [23:0] ldat;
    logic [23:0] base = 24'h0;
    logic [23:0] tgt;
    logic [31:0] q;
    logic [31:0] ctl [4] = '{32'hC003, 32'hC003, 32'h8003, 32'hC005};
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    int e0;
    initial
    begin
        forever #20 i_clk = ~i_clk;
    end
    fbe_flash_seq #(.ERASE_CYCLES(4), .WORD_CYCLES(2)) uut (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_avs_address(av_adr), .i_avs_read(av_rd), .i_avs_write(av_wr),
        .i_avs_writedata(av_wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .o_cpu_stall(stall), .o_fl_erase(fl_er), .o_fl_write(fl_wr),
        .o_fl_addr(fl_adr), .o_fl_wdata(fl_wd), .o_latch_idx(lidx), .i_latch_data(ldat));
    fbe_flash_model u_fl (.i_clk(i_clk), .i_fl_erase(fl_er), .i_fl_write(fl_wr),
        .i_fl_addr(fl_adr), .i_fl_wdata(fl_wd), .i_latch_idx(lidx), .i_base(base),
        .o_latch_data(ldat));
    // ********
    // helpers
    // ********
    function logic [31:0] refused_bits(input logic [31:0] v);
        return {30'h0, v[15], v[13]};
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // request held until a rising edge samples waitrequest low; data taken at that edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        av_adr <= a;
        av_wr <= w;
        av_rd <= ~w;
        av_wd <= d;
        @(posedge i_clk);
        while (wreq !== 1'b0)
            @(posedge i_clk);
        q = rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask
    task go(input logic [31:0] c);
        bus(1'b1, 4'hC, 32'h55);
        bus(1'b1, 4'hC, 32'hAA);
        bus(1'b1, 4'h0, c);
        repeat (2) @(posedge i_clk);
        check({31'h0, stall}, 32'h1);
    endtask
    task wait_done;
        q = 32'h8000;
        while (q[15] === 1'b1)
            bus(1'b0, 4'h0, 32'h0);
    endtask
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            n_fail++;
            wrap_up;
        end
    end
    // ********
    // main sequence
    // ********
    initial
    begin
        void'($urandom(32'hA17BF6F8));
        base = 24'($urandom);
        tgt = 24'($urandom);
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        check(q, 32'h0);
        bus(1'b1, 4'h4, {16'h0, tgt[15:0]});
        bus(1'b1, 4'h8, {24'h0, tgt[23:16]});
        bus(1'b1, 4'h0, 32'h4003);
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'h4003);
        go(32'hC003);
        wait_done;
        check(u_fl.n_erase, 1);
        check(u_fl.erase_addr, tgt);
        for (int r = 0; r < 2; r++)
        begin
            bus(1'b1, 4'h4, {16'h0, tgt[15:0]});
            bus(1'b1, 4'h8, {24'h0, tgt[23:16]});
            go(32'hC002);
            wait_done;
            check(u_fl.n_write, 128 * (r + 1));
            check(u_fl.wr_addr, tgt + 24'h7F);
            tgt = tgt + 24'h80;
        end
        check(u_fl.n_bad, 0);
        for (int c = 0; c < 4; c++)
        begin
            e0 = u_fl.n_erase + u_fl.n_write;
            if (c == 2)
                bus(1'b1, 4'h0, 32'h3);
            if (c != 0)
                bus(1'b1, 4'hC, 32'h55);
            if (c == 1)
                bus(1'b1, 4'hC, 32'h12);
            if (c != 0)
                bus(1'b1, 4'hC, 32'hAA);
            bus(1'b1, 4'h0, ctl[c]);
            repeat (3) @(posedge i_clk);
            check({31'h0, stall}, 32'h0);
            bus(1'b0, 4'h0, 32'h0);
            check(refused_bits(q), 32'h1);
            check(u_fl.n_erase + u_fl.n_write, e0);
        end
        wrap_up;
    end
endmodule // flash_block_erase_row_program_bench
`default_nettype wire
